// >>> core/dtu_regs.svh
/*
 Register offsets, field positions, reset values and divider counts of the
 dual timer and up/down timer block.
 Assumes an APB slave with byte addresses, one aligned 32-bit word per register.
*/
// Functional notes
// (R1) Mode 00: 8-bit count, divide-by-32 prescaler
// (R2) Mode 01 16-bit; mode 10 low-byte reload
// (R3) Mode 11 splits timer 0; timer 1 holds
// (R4) Timer function counts every machine cycle
// (R5) Counter function counts sampled falling pin edges
// (R6) Gate bit lets gate pin gate counting
// (R7) Timer 2 16-bit, selectable timer or counter
// (R8) Timer 2 reload on overflow or trigger
// (R9) Up/down: trigger level sets count direction
// (R10) Capture mode: trigger edge copies count
// (R11) Baud mode: osc/2, no overflow flag
// (R12) Baud mode reloads on every overflow
// (R13) Overflow strobes of timers 1, 2 out
// (R14) Timers count only while run bit set
// (R15) Overflow sets sticky flag, interrupt request
// (R16) Gate set: run and gate pin high
`ifndef DTU_REGS_SVH
`define DTU_REGS_SVH
`define DTU_OFF_MODE 8'h00
`define DTU_OFF_RUN 8'h04
`define DTU_OFF_CNT0 8'h08
`define DTU_OFF_CNT1 8'h0C
`define DTU_OFF_T2CTL 8'h10
`define DTU_OFF_TIMER_TWO_MODE 8'h14
`define DTU_OFF_CNT2 8'h18
`define DTU_OFF_RLD2 8'h1C
`define DTU_OFF_STAT 8'h20
`define DTU_OFF_MASK 8'h24
`define DTU_ADDR_FLD 7:0
`define DTU_T0_FLD 3:0
`define DTU_T1_FLD 7:4
`define DTU_HI_FLD 15:8
`define DTU_LO_FLD 7:0
`define DTU_PRE_FLD 4:0
`define DTU_B_RUN0 0
`define DTU_B_RUN1 1
`define DTU_B_CPRL 0
`define DTU_B_CT2 1
`define DTU_B_TR2 2
`define DTU_B_TRIGGER_PIN_ENABLE 3
`define DTU_B_TX_CLOCK_SRC_SEL 4
`define DTU_B_RCLK 5
`define DTU_B_UPDOWN_ENABLE 0
`define DTU_S_OVF0 0
`define DTU_S_OVF1 1
`define DTU_S_OVF2 2
`define DTU_S_TRIG2 3
`define DTU_M_PRESC 2'h0
`define DTU_M_FULL 2'h1
`define DTU_M_RELOAD 2'h2
`define DTU_M_SPLIT 2'h3
`define DTU_RST_MODE 8'h00
`define DTU_RST_RUN 2'h0
`define DTU_RST_CNT 16'h0000
`define DTU_RST_T2CTL 6'h00
`define DTU_RST_TIMER_TWO_MODE 1'h0
`define DTU_RST_FLAGS 4'h0
`define DTU_RST_MC 4'h0
`define DTU_CNT_TOP 16'hFFFF
`define DTU_MC_LAST 4'hB
`endif

// >>> core/dtu_pkg.sv
/*
 Types of the dual timer and up/down timer block.
 Assumes dtu_regs.svh supplies the numeric constants.
*/
`default_nettype none
package dtu_pkg;
	typedef struct packed {
		logic count_in_zero;
		logic count_in_one;
		logic count_in_two;
		logic gate_pin_zero;
		logic gate_pin_one;
		logic trigger_pin;
	} dtu_pins_t;
	typedef struct packed {
		logic gate;
		logic count_sel;
		logic mode_sel_hi;
		logic mode_sel_lo;
	} dtu_nib_t;
	typedef struct packed {
		logic [15:0] cnt;
		logic ovf;
	} dtu_step_t;
	typedef struct packed {
		logic t1_ovf;
		logic t2_ovf;
	} dtu_strobe_t;
	typedef enum logic [4:0] {
		DTU_T2_OFF = 5'h01,
		DTU_T2_BAUD = 5'h02,
		DTU_T2_CAP = 5'h04,
		DTU_T2_RELOAD = 5'h08,
		DTU_T2_UPDN = 5'h10
	} dtu_t2_mode_t;
endpackage : dtu_pkg
`default_nettype wire

// >>> core/dtu_timers.sv
/*
 Timers 0 and 1 (four modes) and up/down timer 2, with APB registers,
 sticky flags, interrupt mask and overflow strobes for the serial port.
 Assumes pclk is the oscillator clock; pin inputs are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dtu_regs.svh"
module dtu_timers (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire dtu_pkg::dtu_pins_t pins,
	output dtu_pkg::dtu_strobe_t baud_strobe,
	output logic irq
);
	import dtu_pkg::*;

	logic [7:0] timer01_mode_reg, timer01_mode_next;
	logic [1:0] run_reg, run_next;
	logic [5:0] timer_two_control_reg, timer_two_control_next;
	logic timer_two_mode_reg, timer_two_mode_next;
	logic [15:0] cnt0_reg, cnt0_next, cnt1_reg, cnt1_next;
	logic [15:0] cnt2_reg, cnt2_next, rld2_reg, rld2_next;
	logic [3:0] stat_reg, stat_next, mask_reg, mask_next;
	logic [3:0] mc_reg, mc_next;
	logic half_reg, half_next;
	dtu_pins_t s1_reg, s2_reg, samp_reg, samp_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next, pslverr_reg, pslverr_next;
	logic irq_reg, irq_next;
	dtu_strobe_t strb_reg, strb_next;

	logic mc_tick, fall0, fall1, fall2, trig_fall, inc0, inc1, inc2, inc_th0;
	logic ovf0, ovf1, tf2, timer_two_trigger_flag, wr, hit;
	logic [8:0] th0_sum;
	logic [7:0] addr;
	dtu_nib_t nib0, nib1;
	dtu_step_t st0, st1;
	dtu_t2_mode_t t2_mode;

	// One count step of timer 0 or 1 in the given mode
	function automatic dtu_step_t step01(input logic [1:0] mode, input logic [15:0] cnt, input logic inc);
		dtu_step_t r;
		logic [5:0] pre;
		logic [8:0] b;
		logic [16:0] w;
		r.cnt = cnt;
		r.ovf = 1'b0;
		pre = {1'b0, cnt[`DTU_PRE_FLD]} + 6'h01;
		b = {1'b0, cnt[`DTU_LO_FLD]} + 9'h001;
		w = {1'b0, cnt} + 17'h00001;
		if (inc)
		begin
			case (mode)
				`DTU_M_PRESC:
				begin
					r.cnt[`DTU_PRE_FLD] = pre[4:0]; // [R1]
					if (pre[5])
					begin
						b = {1'b0, cnt[`DTU_HI_FLD]} + 9'h001;
						r.cnt[`DTU_HI_FLD] = b[7:0];
						r.ovf = b[8];
					end
				end
				`DTU_M_FULL:
				begin
					r.cnt = w[15:0]; // [R2]
					r.ovf = w[16];
				end
				`DTU_M_RELOAD:
				begin
					r.cnt[`DTU_LO_FLD] = b[8] ? cnt[`DTU_HI_FLD] : b[7:0]; // [R2]
					r.ovf = b[8];
				end
				default:
				begin
					r.cnt[`DTU_LO_FLD] = b[7:0]; // [R3]
					r.ovf = b[8];
				end
			endcase
		end
		return r;
	endfunction : step01

	always_comb
	begin
		addr = paddr[`DTU_ADDR_FLD];
		mc_tick = (mc_reg == `DTU_MC_LAST);
		mc_next = mc_tick ? `DTU_RST_MC : 4'(mc_reg + 4'h1);
		half_next = ~half_reg;
		// Pins sampled once per machine cycle; an edge needs two samples
		samp_next = mc_tick ? s2_reg : samp_reg;
		fall0 = mc_tick & samp_reg.count_in_zero & ~s2_reg.count_in_zero; // [R5]
		fall1 = mc_tick & samp_reg.count_in_one & ~s2_reg.count_in_one; // [R5]
		fall2 = mc_tick & samp_reg.count_in_two & ~s2_reg.count_in_two; // [R5]
		trig_fall = mc_tick & samp_reg.trigger_pin & ~s2_reg.trigger_pin
			& timer_two_control_reg[`DTU_B_TRIGGER_PIN_ENABLE];

		nib0 = timer01_mode_reg[`DTU_T0_FLD];
		nib1 = timer01_mode_reg[`DTU_T1_FLD];
		inc0 = run_reg[`DTU_B_RUN0] & (~nib0.gate | s2_reg.gate_pin_zero) // [R6] [R14] [R16]
			& (nib0.count_sel ? fall0 : mc_tick); // [R4] [R5]
		inc1 = run_reg[`DTU_B_RUN1] & (~nib1.gate | s2_reg.gate_pin_one) // [R6] [R14] [R16]
			& (nib1.count_sel ? fall1 : mc_tick)
			& ({nib1.mode_sel_hi, nib1.mode_sel_lo} != `DTU_M_SPLIT); // [R3]
		st0 = step01({nib0.mode_sel_hi, nib0.mode_sel_lo}, cnt0_reg, inc0);
		st1 = step01({nib1.mode_sel_hi, nib1.mode_sel_lo}, cnt1_reg, inc1);
		// Split mode: high byte of timer 0 is a pure timer run by timer 1's run bit
		inc_th0 = mc_tick & run_reg[`DTU_B_RUN1];
		th0_sum = {1'b0, cnt0_reg[`DTU_HI_FLD]} + 9'h001;
		cnt0_next = st0.cnt;
		ovf0 = st0.ovf;
		ovf1 = st1.ovf;
		if ({nib0.mode_sel_hi, nib0.mode_sel_lo} == `DTU_M_SPLIT)
		begin
			if (inc_th0)
				cnt0_next[`DTU_HI_FLD] = th0_sum[7:0]; // [R3]
			ovf1 = inc_th0 & th0_sum[8];
		end
		cnt1_next = st1.cnt;

		if (!timer_two_control_reg[`DTU_B_TR2])
			t2_mode = DTU_T2_OFF; // [R14]
		else if (timer_two_control_reg[`DTU_B_TX_CLOCK_SRC_SEL] | timer_two_control_reg[`DTU_B_RCLK])
			t2_mode = DTU_T2_BAUD;
		else if (timer_two_control_reg[`DTU_B_CPRL])
			t2_mode = DTU_T2_CAP;
		else if (timer_two_mode_reg)
			t2_mode = DTU_T2_UPDN;
		else
			t2_mode = DTU_T2_RELOAD;
		inc2 = timer_two_control_reg[`DTU_B_CT2] ? fall2 // [R7]
			: ((t2_mode == DTU_T2_BAUD) ? half_reg : mc_tick); // [R11]
		cnt2_next = cnt2_reg;
		rld2_next = rld2_reg;
		tf2 = 1'b0;
		timer_two_trigger_flag = 1'b0;
		strb_next.t2_ovf = 1'b0;
		case (t2_mode)
			DTU_T2_OFF:
				cnt2_next = cnt2_reg; // [R14]
			DTU_T2_BAUD:
			begin
				if (inc2)
				begin
					cnt2_next = (cnt2_reg == `DTU_CNT_TOP) ? rld2_reg : 16'(cnt2_reg + 16'h0001); // [R12]
					strb_next.t2_ovf = (cnt2_reg == `DTU_CNT_TOP); // [R11] [R13]
				end
				timer_two_trigger_flag = trig_fall; // [R11]
			end
			DTU_T2_CAP:
			begin
				if (inc2)
				begin
					cnt2_next = 16'(cnt2_reg + 16'h0001); // [R10]
					tf2 = (cnt2_reg == `DTU_CNT_TOP);
				end
				if (trig_fall)
					rld2_next = cnt2_reg; // [R10]
				timer_two_trigger_flag = trig_fall;
			end
			DTU_T2_RELOAD:
			begin
				if (inc2)
				begin
					cnt2_next = (cnt2_reg == `DTU_CNT_TOP) ? rld2_reg : 16'(cnt2_reg + 16'h0001); // [R8]
					tf2 = (cnt2_reg == `DTU_CNT_TOP);
				end
				// Trigger reload wins over a count in the same cycle
				if (trig_fall)
					cnt2_next = rld2_reg; // [R8]
				timer_two_trigger_flag = trig_fall;
			end
			DTU_T2_UPDN:
			begin
				if (inc2 && s2_reg.trigger_pin)
				begin
					cnt2_next = (cnt2_reg == `DTU_CNT_TOP) ? rld2_reg : 16'(cnt2_reg + 16'h0001); // [R9]
					tf2 = (cnt2_reg == `DTU_CNT_TOP);
				end
				else if (inc2)
				begin
					cnt2_next = (cnt2_reg == rld2_reg) ? `DTU_CNT_TOP : 16'(cnt2_reg - 16'h0001); // [R9]
					tf2 = (cnt2_reg == rld2_reg);
				end
			end
			default:
				cnt2_next = cnt2_reg;
		endcase
		if (t2_mode != DTU_T2_BAUD)
			strb_next.t2_ovf = tf2; // [R13]
		strb_next.t1_ovf = st1.ovf; // [R13]

		// APB: one wait state, then pready for one cycle
		pready_next = psel & penable & ~pready_reg;
		wr = psel & penable & pready_reg & pwrite;
		hit = 1'b1;
		prdata_next = 32'h0000_0000;
		case (addr)
			`DTU_OFF_MODE: prdata_next[7:0] = timer01_mode_reg;
			`DTU_OFF_RUN: prdata_next[1:0] = run_reg;
			`DTU_OFF_CNT0: prdata_next[15:0] = cnt0_reg;
			`DTU_OFF_CNT1: prdata_next[15:0] = cnt1_reg;
			`DTU_OFF_T2CTL: prdata_next[5:0] = timer_two_control_reg;
			`DTU_OFF_TIMER_TWO_MODE: prdata_next[0] = timer_two_mode_reg;
			`DTU_OFF_CNT2: prdata_next[15:0] = cnt2_reg;
			`DTU_OFF_RLD2: prdata_next[15:0] = rld2_reg;
			`DTU_OFF_STAT: prdata_next[3:0] = stat_reg;
			`DTU_OFF_MASK: prdata_next[3:0] = mask_reg;
			default: hit = 1'b0;
		endcase
		if (!pready_next || pwrite)
			prdata_next = 32'h0000_0000;
		pslverr_next = pready_next & ~hit;

		timer01_mode_next = timer01_mode_reg;
		run_next = run_reg;
		timer_two_control_next = timer_two_control_reg;
		timer_two_mode_next = timer_two_mode_reg;
		mask_next = mask_reg;
		// Hardware set wins over a write-one clear in the same cycle
		stat_next = stat_reg;
		if (wr && addr == `DTU_OFF_STAT)
			stat_next = stat_reg & ~pwdata[3:0];
		stat_next[`DTU_S_OVF0] = stat_next[`DTU_S_OVF0] | ovf0; // [R15]
		stat_next[`DTU_S_OVF1] = stat_next[`DTU_S_OVF1] | ovf1; // [R15]
		stat_next[`DTU_S_OVF2] = stat_next[`DTU_S_OVF2] | tf2; // [R15] [R11]
		stat_next[`DTU_S_TRIG2] = stat_next[`DTU_S_TRIG2] | timer_two_trigger_flag;
		// Software writes to counters override the count step
		if (wr)
		begin
			case (addr)
				`DTU_OFF_MODE: timer01_mode_next = pwdata[7:0];
				`DTU_OFF_RUN: run_next = pwdata[1:0];
				`DTU_OFF_CNT0: cnt0_next = pwdata[15:0];
				`DTU_OFF_CNT1: cnt1_next = pwdata[15:0];
				`DTU_OFF_T2CTL: timer_two_control_next = pwdata[5:0];
				`DTU_OFF_TIMER_TWO_MODE: timer_two_mode_next = pwdata[0];
				`DTU_OFF_CNT2: cnt2_next = pwdata[15:0];
				`DTU_OFF_RLD2: rld2_next = pwdata[15:0];
				`DTU_OFF_MASK: mask_next = pwdata[3:0];
				default: mask_next = mask_reg;
			endcase
		end
		irq_next = |(stat_reg & mask_reg); // [R15]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer01_mode_reg <= `DTU_RST_MODE;
			run_reg <= `DTU_RST_RUN;
			timer_two_control_reg <= `DTU_RST_T2CTL;
			timer_two_mode_reg <= `DTU_RST_TIMER_TWO_MODE;
			cnt0_reg <= `DTU_RST_CNT;
			cnt1_reg <= `DTU_RST_CNT;
			cnt2_reg <= `DTU_RST_CNT;
			rld2_reg <= `DTU_RST_CNT;
			stat_reg <= `DTU_RST_FLAGS;
			mask_reg <= `DTU_RST_FLAGS;
			mc_reg <= `DTU_RST_MC;
			half_reg <= 1'b0;
			s1_reg <= '0;
			s2_reg <= '0;
			samp_reg <= '0;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			irq_reg <= 1'b0;
			strb_reg <= '0;
		end
		else
		begin
			timer01_mode_reg <= timer01_mode_next;
			run_reg <= run_next;
			timer_two_control_reg <= timer_two_control_next;
			timer_two_mode_reg <= timer_two_mode_next;
			cnt0_reg <= cnt0_next;
			cnt1_reg <= cnt1_next;
			cnt2_reg <= cnt2_next;
			rld2_reg <= rld2_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			mc_reg <= mc_next;
			half_reg <= half_next;
			s1_reg <= pins;
			s2_reg <= s1_reg;
			samp_reg <= samp_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			irq_reg <= irq_next;
			strb_reg <= strb_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;
	assign baud_strobe = strb_reg;
endmodule : dtu_timers
`default_nettype wire

// >>> test/dtu_checker.sv
/*
 Checker of bus answers, strobes and interrupt line of dtu_timers.
 Assumes a bind to dtu_timers; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module dtu_checker
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire dtu_pkg::dtu_pins_t pins,
	input wire dtu_pkg::dtu_strobe_t baud_strobe,
	input wire logic irq
);
	import dtu_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no answer after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_cause: assert property (pready |-> psel && penable)
		else $error("pready without access");
	a_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad error answer");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_t1_pulse: assert property (baud_strobe.t1_ovf |=> !baud_strobe.t1_ovf)
		else $error("timer one strobe too long");
	a_t2_pulse: assert property (baud_strobe.t2_ovf |=> !baud_strobe.t2_ovf)
		else $error("timer two strobe too long");
	a_irq_clear: assert property ($fell(irq) |-> $past(pready && pwrite, 2))
		else $error("irq dropped without a write");
endmodule : dtu_checker
`default_nettype wire

// >>> test/dtu_far_model.sv
/*
 Far side of dtu_timers: count, gate and trigger pins, serial port.
 Assumes the bench sets a pulse total and the gate and trigger levels.
*/
`timescale 1ns/1ps
`default_nettype none
module dtu_far_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] pulses,
	input wire logic [2:0] lvl,
	input wire dtu_pkg::dtu_strobe_t baud_strobe,
	output dtu_pkg::dtu_pins_t pins,
	output logic [15:0] t1_seen,
	output logic [15:0] t2_gap
);
	import dtu_pkg::*;
	logic [7:0] done_reg;
	logic [4:0] hold_reg;
	logic [15:0] gap_reg;
	logic pin_reg;
	// One pulse train on all count pins; idle high as with pull-ups
	assign pins = {pin_reg, pin_reg, pin_reg, lvl};
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			{done_reg, hold_reg, pin_reg} <= 14'h1;
			{t1_seen, t2_gap, gap_reg} <= 48'h0;
		end
		else
		begin
			// Each level held 24 cycles, two machine cycles
			hold_reg <= (hold_reg == 5'h17) ? 5'h0 : hold_reg + 5'h1;
			if (hold_reg == 5'h17 && (!pin_reg || done_reg != pulses))
			begin
				pin_reg <= ~pin_reg;
				done_reg <= done_reg + {7'h0, pin_reg};
			end
			t1_seen <= t1_seen + {15'h0, baud_strobe.t1_ovf};
			gap_reg <= baud_strobe.t2_ovf ? 16'h1 : gap_reg + 16'h1;
			if (baud_strobe.t2_ovf)
				t2_gap <= gap_reg;
		end
	end
endmodule : dtu_far_model
`default_nettype wire

// >>> test/dtu_timers_tb.sv
/*
 Self-checking bench of dtu_timers, one scenario per timer mode.
 Assumes dtu_far_model on the pins and dtu_checker bound to the design.
*/
`timescale 1ns/1ps
`default_nettype none
module dtu_timers_tb;
	import dtu_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [31:0] paddr, pwdata, prdata, r;
	logic [7:0] pulses;
	logic [2:0] lvl;
	logic [15:0] t1_seen, t2_gap, s1;
	logic [7:0] adr[4] = '{8'h08, 8'h0C, 8'h18, 8'h1C};
	dtu_pins_t pins;
	dtu_strobe_t baud_strobe;
	int err_total, n_compared, seed, i;
	logic [31:0] shadow[$];
	dtu_timers u_dtu_timers (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins(pins), .baud_strobe(baud_strobe), .irq(irq));
	dtu_far_model u_dtu_far_model (.pclk(pclk), .presetn(presetn), .pulses(pulses), .lvl(lvl),
		.baud_strobe(baud_strobe), .pins(pins), .t1_seen(t1_seen), .t2_gap(t2_gap));
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'h1, w, 24'h0, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		{r, e} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		apb(1'h0, a, 32'h0);
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_compared++;
		if (got !== ex)
		begin
			$display("wrong value %s exp %h got %h", nm, ex, got);
			err_total++;
		end
	endtask : chk
	task automatic chk1(input string nm, input logic ex, input logic got);
		chk(nm, {31'h0, ex}, {31'h0, got});
	endtask : chk1
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	initial
	begin
		pclk = 1'h0;
		forever #50 pclk = ~pclk;
	end
	// About 1400 cycles needed
	initial
	begin
		repeat (10000) @(posedge pclk);
		err_total++;
		finish_test();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pulses, lvl} = {4'h0, 64'h0, 8'h0, 3'h7};
		{seed, err_total, n_compared} = {32'hFE7F, 64'h0};
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		for (i = 0; i < 10; i++)
		begin
			rd(8'(i * 4));
			chk("reset", 32'h0, r);
		end
		rd(8'h28);
		chk1("slverr", 1'h1, e);
		// Stopped counters keep written values
		for (i = 0; i < 4; i++)
		begin
			shadow.push_back($random(seed) & 32'hFFFF);
			wr(adr[i], shadow[i]);
			cyc(30);
			rd(adr[i]);
			chk("hold", shadow[i], r);
		end
		wr(8'h00, 32'h01);
		wr(8'h08, 32'hFFFF);
		wr(8'h04, 32'h1);
		cyc(30);
		wr(8'h04, 32'h0);
		rd(8'h08);
		chk1("mc rate", 1'h1, r >= 1 && r <= 3);
		rd(8'h20);
		chk1("flag0", 1'h1, r[0]);
		chk1("masked", 1'h0, irq);
		wr(8'h24, 32'hF);
		cyc(3);
		chk1("irq", 1'h1, irq);
		wr(8'h20, 32'h1);
		cyc(3);
		chk1("irq clr", 1'h0, irq);
		wr(8'h00, 32'h00);
		wr(8'h08, 32'hFF1F);
		wr(8'h04, 32'h1);
		cyc(15);
		wr(8'h04, 32'h0);
		rd(8'h08);
		chk("presc", 32'h0, {24'h0, r[15:8]});
		wr(8'h00, 32'h20);
		wr(8'h0C, 32'hC8FF);
		s1 = t1_seen;
		wr(8'h04, 32'h2);
		cyc(30);
		wr(8'h04, 32'h0);
		rd(8'h0C);
		chk1("reload8", 1'h1, r[15:8] == 8'hC8 && r[7:0] >= 8'hC8);
		chk1("t1 strobe", 1'h1, t1_seen != s1);
		rd(8'h20);
		chk("flags", 32'h3, r);
		wr(8'h20, 32'hF);
		wr(8'h00, 32'h33);
		wr(8'h0C, 32'h1234);
		wr(8'h08, 32'hFF00);
		wr(8'h04, 32'h2);
		cyc(30);
		wr(8'h04, 32'h0);
		rd(8'h0C);
		chk("t1 frozen", 32'h1234, r);
		rd(8'h20);
		chk("split", 32'h2, r);
		wr(8'h20, 32'hF);
		lvl <= 3'h3;
		wr(8'h00, 32'h09);
		wr(8'h08, 32'h5);
		wr(8'h04, 32'h1);
		cyc(40);
		rd(8'h08);
		chk("gated", 32'h5, r);
		lvl <= 3'h7;
		cyc(40);
		rd(8'h08);
		chk1("gate open", 1'h1, r > 5);
		wr(8'h00, 32'h05);
		wr(8'h08, 32'h0);
		pulses <= 8'h3;
		cyc(250);
		wr(8'h04, 32'h0);
		rd(8'h08);
		chk("events", 32'h3, r);
		wr(8'h20, 32'hF);
		wr(8'h1C, 32'hFFF0);
		wr(8'h18, 32'hFFFF);
		wr(8'h10, 32'h04);
		cyc(30);
		wr(8'h18, 32'h0010);
		wr(8'h10, 32'h0C);
		lvl <= 3'h6;
		cyc(40);
		wr(8'h10, 32'h0);
		rd(8'h18);
		chk("t2 load", 32'hFFF, {20'h0, r[15:4]});
		rd(8'h20);
		chk("t2 flags", 32'hC, r);
		wr(8'h20, 32'hF);
		wr(8'h1C, 32'h0);
		wr(8'h18, 32'h0100);
		wr(8'h10, 32'h0D);
		lvl <= 3'h7;
		cyc(30);
		lvl <= 3'h6;
		cyc(30);
		wr(8'h10, 32'h0);
		rd(8'h1C);
		chk("capture", 32'h01, {24'h0, r[15:8]});
		rd(8'h20);
		chk("cap flag", 32'h8, r);
		wr(8'h20, 32'hF);
		wr(8'h14, 32'h1);
		wr(8'h18, 32'h0010);
		wr(8'h10, 32'h04);
		cyc(30);
		wr(8'h10, 32'h0);
		rd(8'h18);
		chk1("down", 1'h1, r < 32'h10 && r > 32'h8);
		wr(8'h14, 32'h0);
		wr(8'h1C, 32'hFFFC);
		wr(8'h18, 32'hFFFC);
		wr(8'h10, 32'h14);
		cyc(60);
		wr(8'h10, 32'h0);
		chk("baud gap", 32'h8, {16'h0, t2_gap});
		rd(8'h20);
		chk("no flag2", 32'h0, r);
		// Receive-side clock select, six counts per wrap, trigger edge armed
		wr(8'h1C, 32'hFFFA);
		lvl <= 3'h7;
		wr(8'h10, 32'h2C);
		cyc(30);
		lvl <= 3'h6;
		cyc(40);
		wr(8'h10, 32'h0);
		chk("rx baud gap", 32'hC, {16'h0, t2_gap});
		rd(8'h20);
		chk("baud trig", 32'h8, r);
		// Timer 2 as event counter, two more falling edges
		wr(8'h18, 32'h0);
		wr(8'h10, 32'h06);
		pulses <= 8'h5;
		cyc(150);
		wr(8'h10, 32'h0);
		rd(8'h18);
		chk("t2 events", 32'h2, r);
		finish_test();
	end
endmodule : dtu_timers_tb
bind dtu_timers dtu_checker u_dtu_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pins(pins), .baud_strobe(baud_strobe), .irq(irq));
`default_nettype wire
